// >>> hdl/pam_pkg.sv
// Constants and types for the phase and amplitude measurement converter.
// Assumes a single 10 MHz clock and an analogue comparator outside.
package pam_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_TIME_NS  = 16500;
  localparam int unsigned CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RES_BITS      = 8;
  localparam int unsigned BIT_CYCLES    = CONV_CYCLES / RES_BITS;
  localparam int unsigned SAMPLE_CYCLES = CONV_CYCLES - RES_BITS * BIT_CYCLES;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned IDX_W         = 3;

  // ==========================================================================
  // Codes and reset values
  localparam logic [7:0] CODE_ZERO  = 8'h00;
  localparam logic [7:0] CODE_FULL  = 8'hff;
  localparam logic [7:0] CODE_MID   = 8'h80;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] IDX_MSB    = 3'h7;
  localparam logic [2:0] IDX_LSB    = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PAM_SRC_NONE   = 3'h0,
    PAM_SRC_PHASE  = 3'h1,
    PAM_SRC_AMPL   = 3'h2,
    PAM_SRC_VDD    = 3'h3,
    PAM_SRC_VDD_A  = 3'h4,
    PAM_SRC_VDD_D  = 3'h5,
    PAM_SRC_VDD_RF = 3'h6,
    PAM_SRC_AUX    = 3'h7
  } pam_src_type;

  typedef enum logic {
    PAM_REF_ABS = 1'b0,
    PAM_REF_REL = 1'b1
  } pam_ref_type;

  typedef enum logic [1:0] {
    PAM_ST_IDLE    = 2'b00,
    PAM_ST_SAMPLE  = 2'b01,
    PAM_ST_CONVERT = 2'b11,
    PAM_ST_DONE    = 2'b10
  } pam_state_type;

  typedef struct packed {
    logic        start;
    pam_src_type src;
  } pam_cmd_type;

  typedef struct packed {
    pam_src_type mux;
    pam_ref_type ref_mode;
    logic        sample;
    logic [7:0]  dac_code;
  } pam_ctrl_type;

endpackage

// >>> hdl/pam_adc_measure.sv
// Control of the 8-bit measurement converter and its input multiplexer.
// Assumes an analogue comparator and reference DAC outside; the comparator
// level arrives asynchronously and is synchronised here.
// Conversion time is counted in 100 ns clock cycles, not carrier cycles.
`timescale 1ns/1ps

module pam_adc_measure (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire pam_pkg::pam_cmd_type  cmd_in,
  input  wire logic                  comp_in,
  output logic                       [7:0] result_out,
  output pam_pkg::pam_ctrl_type      ctrl_out,
  output logic                       busy_out,
  output logic                       done_out,
  output logic                       refused_out
);
  import pam_pkg::*;

  // ==========================================================================
  // Comparator synchroniser
  logic comp_meta;
  logic comp_sync;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  // ==========================================================================
  // State and datapath registers
  pam_state_type state;
  pam_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [IDX_W-1:0] bit_idx;
  logic [IDX_W-1:0] next_bit_idx;
  logic [7:0]       sar;
  logic [7:0]       next_sar;
  logic [7:0]       result;
  logic [7:0]       next_result;
  pam_src_type      src;
  pam_src_type      next_src;
  pam_ref_type      ref_mode;
  pam_ref_type      next_ref_mode;
  logic             sample;
  logic             busy;
  logic             done;
  logic             refused;

  // ==========================================================================
  // State decode
  wire logic st_idle    = (state == PAM_ST_IDLE);
  wire logic st_sample  = (state == PAM_ST_SAMPLE);
  wire logic st_convert = (state == PAM_ST_CONVERT);
  wire logic st_done    = (state == PAM_ST_DONE);
  wire logic in_work    = st_sample || st_convert;
  wire logic can_start  = st_idle || st_done;

  // ==========================================================================
  // Command decode
  wire logic cmd_take   = cmd_in.start && can_start;
  wire logic cmd_refuse = cmd_in.start && in_work;
  wire logic cmd_phase  = (cmd_in.src == PAM_SRC_PHASE);
  // Phase alone uses relative references
  wire pam_ref_type cmd_ref = cmd_phase ? PAM_REF_REL :
                                          PAM_REF_ABS;

  // ==========================================================================
  // Step timing
  // Counts reload one short, so each phase lasts its full count
  wire logic             cnt_zero   = (cnt == '0);
  wire logic             last_bit   = (bit_idx == IDX_LSB);
  wire logic             sample_end = st_sample && cnt_zero;
  wire logic             step_end   = st_convert && cnt_zero;
  wire logic             conv_end   = step_end && last_bit;
  wire logic             step_next  = step_end && !last_bit;
  wire logic [CNT_W-1:0] cnt_dec    = cnt - 1'b1;
  wire logic [CNT_W-1:0] cnt_sample = CNT_W'(SAMPLE_CYCLES - 1);
  wire logic [CNT_W-1:0] cnt_bit    = CNT_W'(BIT_CYCLES - 1);
  wire logic [IDX_W-1:0] idx_dec    = bit_idx - 1'b1;

  // ==========================================================================
  // Per-bit trial logic
  // One slice per code bit: decide the trial bit, raise the one below
  wire logic [7:0] bit_trial;
  wire logic [7:0] bit_below;
  wire logic [7:0] decided;
  wire logic [7:0] next_trial;

  for (genvar b = 0; b < RES_BITS; b++) begin : g_bit
    assign bit_trial[b]  = (bit_idx == IDX_W'(b));
    if (b < RES_BITS - 1) begin : g_below
      assign bit_below[b] = (bit_idx == IDX_W'(b + 1));
    end else begin : g_top
      assign bit_below[b] = 1'b0;
    end
    // Higher level, higher code; phase codes fall as phase grows
    assign decided[b]    = bit_trial[b] ? comp_sync : sar[b];
    assign next_trial[b] = decided[b] | bit_below[b];
  end

  // ==========================================================================
  // State machine
  always_comb begin
    next_state = state;
    case (state)
      PAM_ST_IDLE, PAM_ST_DONE: begin
        next_state = cmd_take ? PAM_ST_SAMPLE : PAM_ST_IDLE;
      end
      PAM_ST_SAMPLE: begin
        if (sample_end) begin
          next_state = PAM_ST_CONVERT;
        end
      end
      PAM_ST_CONVERT: begin
        if (conv_end) begin
          next_state = PAM_ST_DONE;
        end
      end
      default: begin
        next_state = PAM_ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Step counter and bit index
  always_comb begin
    next_cnt     = cnt;
    next_bit_idx = bit_idx;
    case (state)
      PAM_ST_IDLE, PAM_ST_DONE: begin
        if (cmd_take) begin
          next_cnt = cnt_sample;
        end
      end
      PAM_ST_SAMPLE: begin
        if (sample_end) begin
          next_cnt     = cnt_bit;
          next_bit_idx = IDX_MSB;
        end else begin
          next_cnt = cnt_dec;
        end
      end
      PAM_ST_CONVERT: begin
        if (!cnt_zero) begin
          next_cnt = cnt_dec;
        end else if (step_next) begin
          next_cnt     = cnt_bit;
          next_bit_idx = idx_dec;
        end
      end
      default: begin
        next_cnt     = '0;
        next_bit_idx = IDX_MSB;
      end
    endcase
  end

  // ==========================================================================
  // Trial code and result
  always_comb begin
    next_sar    = sar;
    next_result = result;
    case (state)
      PAM_ST_IDLE, PAM_ST_DONE: begin
        if (cmd_take) begin
          next_sar = CODE_ZERO;
        end
      end
      PAM_ST_SAMPLE: begin
        if (sample_end) begin
          next_sar = CODE_MID;
        end
      end
      PAM_ST_CONVERT: begin
        if (conv_end) begin
          // Full binary search ends at 00h or FFh at the rails
          next_sar    = decided;
          next_result = decided;
        end else if (step_next) begin
          next_sar = next_trial;
        end
      end
      default: begin
        next_sar = CODE_ZERO;
      end
    endcase
  end

  // ==========================================================================
  // Source and reference selection
  always_comb begin
    next_src      = src;
    next_ref_mode = ref_mode;
    case (state)
      PAM_ST_IDLE, PAM_ST_DONE: begin
        // Routing dropped between commands
        next_src      = PAM_SRC_NONE;
        next_ref_mode = PAM_REF_ABS;
        if (cmd_take) begin
          next_src      = cmd_in.src;
          next_ref_mode = cmd_ref;
        end
      end
      PAM_ST_SAMPLE, PAM_ST_CONVERT: begin
        // Held for the whole conversion
        next_src      = src;
        next_ref_mode = ref_mode;
      end
      default: begin
        next_src      = PAM_SRC_NONE;
        next_ref_mode = PAM_REF_ABS;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PAM_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt     <= '0;
      bit_idx <= IDX_MSB;
    end else begin
      cnt     <= next_cnt;
      bit_idx <= next_bit_idx;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sar    <= CODE_ZERO;
      result <= RESULT_RST;
    end else begin
      sar    <= next_sar;
      result <= next_result;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src      <= PAM_SRC_NONE;
      ref_mode <= PAM_REF_ABS;
    end else begin
      src      <= next_src;
      ref_mode <= next_ref_mode;
    end
  end

  // ==========================================================================
  // Status flags
  // Taken from the next state so they line up with the state register
  wire logic next_sample  = (next_state == PAM_ST_SAMPLE);
  wire logic next_busy    = (next_state == PAM_ST_SAMPLE) ||
                            (next_state == PAM_ST_CONVERT);
  wire logic next_done    = (next_state == PAM_ST_DONE);
  // A refused command leaves the conversion untouched
  wire logic next_refused = cmd_refuse;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      sample <= next_sample;
      busy   <= next_busy;
      done   <= next_done;
    end
  end

  // Refusal pulse kept apart from the conversion flags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      refused <= 1'b0;
    end else begin
      refused <= next_refused;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign result_out        = result;
  assign ctrl_out.mux      = src;
  assign ctrl_out.ref_mode = ref_mode;
  assign ctrl_out.sample   = sample;
  assign ctrl_out.dac_code = sar;
  assign busy_out          = busy;
  assign done_out          = done;
  assign refused_out       = refused;

endmodule // pam_adc_measure

// >>> testbench/pam_comp_model.sv
// Ideal comparator that stands in for the analogue front end.
// Assumes level_in holds the input already scaled to converter codes.
`timescale 1ns/1ps
module pam_comp_model (
  input  wire logic [7:0] dac_code_in,
  input  wire logic [7:0] level_in,
  output logic            comp_out
);
  // ==========================================================================
  // Reference window mapped onto codes 00h..ffh
  assign comp_out = (level_in >= dac_code_in);
endmodule // pam_comp_model

// >>> testbench/pam_adc_chk.sv
// Assertions on the measurement converter control ports.
// Assumes binding to pam_adc_measure.
`timescale 1ns/1ps
module pam_adc_chk import pam_pkg::*; (
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire pam_cmd_type  cmd_in,
  input wire logic [7:0]   result_out,
  input wire pam_ctrl_type ctrl_out,
  input wire logic         busy_out,
  input wire logic         done_out,
  input wire logic         refused_out
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_take;
    cmd_in.start && !busy_out |=>
      busy_out && ctrl_out.mux == $past(cmd_in.src);
  endproperty
  property p_ref;
    busy_out |-> ctrl_out.ref_mode == (ctrl_out.mux == PAM_SRC_PHASE);
  endproperty
  property p_len;
    $rose(busy_out) |-> ##165 done_out && !busy_out;
  endproperty
  property p_upd;
    $changed(result_out) |-> done_out;
  endproperty
  property p_pulse;
    done_out |=> !done_out;
  endproperty
  property p_refuse;
    cmd_in.start && busy_out |=> refused_out;
  endproperty
  property p_hold;
    busy_out && $past(busy_out) |-> $stable(ctrl_out.mux);
  endproperty
  property p_sample;
    $rose(busy_out) |-> ctrl_out.sample[*5] ##1 !ctrl_out.sample;
  endproperty
  property p_msb;
    $fell(ctrl_out.sample) && busy_out |-> ctrl_out.dac_code == CODE_MID;
  endproperty
  a_take: assert property (p_take) else $error("start not taken");
  a_ref: assert property (p_ref) else $error("wrong ref mode");
  a_len: assert property (p_len) else $error("bad length");
  a_upd: assert property (p_upd) else $error("result moved");
  a_pulse: assert property (p_pulse) else $error("long done");
  a_refuse: assert property (p_refuse) else $error("no refusal");
  a_hold: assert property (p_hold) else $error("mux moved");
  a_sample: assert property (p_sample) else $error("bad sample");
  a_msb: assert property (p_msb) else $error("bad first trial");
  c_phase: cover property (busy_out && ctrl_out.ref_mode);
  c_refuse: cover property (refused_out);
  c_full: cover property (done_out && result_out == CODE_FULL);
endmodule // pam_adc_chk

bind pam_adc_measure pam_adc_chk pam_adc_chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
  .result_out(result_out), .ctrl_out(ctrl_out), .busy_out(busy_out),
  .done_out(done_out), .refused_out(refused_out));

// >>> testbench/phase_amplitude_adc_measure_test.sv
// Self-checking bench for the measurement converter control.
// Assumes an ideal comparator model on comp_in.
`timescale 1ns/1ps
module phase_amplitude_adc_measure_test;
  import pam_pkg::*;
  // ==========================================================================
  // Signals and instances
  logic         clk_in = 0, rst_in = 1, comp_in, busy_out, done_out;
  logic         refused_out;
  logic [7:0]   result_out, level = 8'h00;
  pam_cmd_type  cmd_in = '0;
  pam_ctrl_type ctrl_out;
  int           errors = 0, tests_run = 0;
  pam_adc_measure pam_adc_measure_i (.clk_in(clk_in), .rst_in(rst_in),
    .cmd_in(cmd_in), .comp_in(comp_in), .result_out(result_out),
    .ctrl_out(ctrl_out), .busy_out(busy_out), .done_out(done_out),
    .refused_out(refused_out));
  pam_comp_model pam_comp_model_i (.dac_code_in(ctrl_out.dac_code),
    .level_in(level), .comp_out(comp_in));
  initial forever #50 clk_in = ~clk_in;
  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t ns: %s", $time, m);
  endtask
  task automatic wrap_up;
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Poke holds start one cycle longer, so it lands while busy
  task automatic measure(input pam_src_type s, input logic [7:0] v,
                         input bit poke);
    int n;
    n = 0;
    level = v;
    cmd_in = '{1'b1, s};
    do begin
      @(posedge clk_in);
      #10;
      n++;
      if (n == 1) cmd_in.start = poke;
      if (n == 2) begin
        cmd_in.start = 1'b0;
        tests_run += 3;
        if (refused_out !== poke) fail("refusal");
        if (ctrl_out.mux !== s) fail("mux");
        if (ctrl_out.ref_mode !== (s == PAM_SRC_PHASE)) fail("ref");
      end
    end while (done_out !== 1'b1 && n < 300);
    tests_run += 2;
    if (n !== 166) fail("conversion length");
    if (result_out !== v) fail("result");
  endtask
  // ==========================================================================
  // Scenarios
  // Every output at its reset value
  task automatic test_reset;
    tests_run += 2;
    if (result_out !== RESULT_RST || ctrl_out !== '0) fail("rst");
    if ({busy_out, done_out, refused_out} !== '0) fail("flags");
  endtask
  // Both rails, the second with a start while busy
  task automatic test_rails;
    measure(PAM_SRC_PHASE, CODE_FULL, 1'b0);
    measure(PAM_SRC_AMPL, CODE_ZERO, 1'b1);
  endtask
  // Every source once, each with its own level
  task automatic test_sources;
    for (int i = 0; i < 8; i++) begin
      measure(pam_src_type'(i), 8'h5a ^ 8'(i), 1'b0);
    end
  endtask
  // Mid-scale phase level
  task automatic test_phase_mid;
    measure(PAM_SRC_PHASE, CODE_MID, 1'b0);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clk_in);
    #10 rst_in = 0;
    test_reset();
    test_rails();
    test_sources();
    test_phase_mid();
    wrap_up();
  end
  initial begin
    #500000;
    errors++;
    wrap_up();
  end
endmodule // phase_amplitude_adc_measure_test
